// *** logic/port_extras.sv ***
// Port pin extras: analog select, weak pull-ups and change detection
`include "port_extras_map.svh"

module port_extras
	import port_extras_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic POR_N_IN,
	input wire logic [3:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	input wire logic [5:0] PIN_IN,
	output logic [5:0] PIN_OUT,
	output logic [5:0] PIN_OE_OUT,
	output logic [5:0] PULLUP_ON_OUT,
	output logic [5:0] DIGITAL_IN_EN_OUT,
	output logic [3:0] ANALOG_PIN_SELECT_OUT,
	output logic [2:0] CONVERTER_CLOCK_SELECT_OUT,
	output logic CONVERTER_USE_RC_OUT,
	output logic [6:0] CONVERTER_DIVISOR_OUT,
	output logic WAKE_OUT,
	output logic IRQ_OUT
);

	bus_req_s req;
	pin_vec_t pin_sync;
	byte_t analog_select_reg;
	byte_t pullup_enable_reg;
	byte_t change_irq_enable_reg;
	pin_vec_t port_latch_reg;
	pin_vec_t direction_reg;
	pin_vec_t last_read_reg;
	logic port_change_flag_reg;
	logic global_irq_enable_reg;
	logic port_irq_enable_reg;
	logic global_pullup_control_n_reg;
	logic master_clear_reg;
	logic osc_pin_mode_reg;
	logic large_variant_reg;
	pin_vec_t analog_pins;
	pin_vec_t digital_read;
	pin_vec_t mismatch;
	logic mismatch_any;
	logic port_access;
	byte_t pullup_view;
	byte_t change_view;
	byte_t analog_select_large_mask;
	byte_t rdata_next;
	conv_clock_e conv_sel;
	chg_state_e chg_state_reg;
	logic flag_set;
	logic flag_clear;
	byte_t port_view;
	byte_t direction_view;
	byte_t irq_view;
	byte_t config_view;

	assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

	// ----------------------------------------
	// Pin input synchronisation
	// ----------------------------------------
	// synchronise before compare
	pin_sync u_sync (
		.clk_in(CORE_CLK_IN),
		.reset_n_in(RESET_N_IN),
		.async_in(PIN_IN),
		.sync_out(pin_sync)
	);

	// ----------------------------------------
	// Analog mapping
	// ----------------------------------------
	// Analog channels 0..3 sit on pins 0,1,2,4
	assign analog_pins = {1'b0, analog_select_reg[3], 1'b0, analog_select_reg[2:0]};
	assign analog_select_large_mask = large_variant_reg ? `ANALOG_SELECT_LARGE_MASK_LARGE : `ANALOG_SELECT_LARGE_MASK_SMALL;
	assign ANALOG_PIN_SELECT_OUT = analog_select_reg[3:0];

	assign digital_read = pin_sync & ~analog_pins;
	assign DIGITAL_IN_EN_OUT = ~analog_pins;
	assign PIN_OUT = port_latch_reg;
	assign PIN_OE_OUT = ~direction_reg;

	// ----------------------------------------
	// Pull-up control
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_pull
			if (i == `INPUT_ONLY_PIN) begin : g_master_clear
				assign PULLUP_ON_OUT[i] = master_clear_reg;
			end else begin : g_io
				// per-pin enable output kills pull-up global gate
				assign PULLUP_ON_OUT[i] = pullup_enable_reg[i] & direction_reg[i]
					& ~global_pullup_control_n_reg & ~analog_pins[i];
			end
		end
	endgenerate

	// ----------------------------------------
	// Converter clock decode
	// ----------------------------------------
	// clock select mapping
	assign conv_sel = conv_clock_e'(analog_select_reg[6:4]);
	assign CONVERTER_CLOCK_SELECT_OUT = analog_select_reg[6:4];
	always_comb begin
		CONVERTER_USE_RC_OUT = 1'b0;
		CONVERTER_DIVISOR_OUT = 7'h02;
		case (conv_sel)
			CONV_DIV2: CONVERTER_DIVISOR_OUT = 7'h02;
			CONV_DIV8: CONVERTER_DIVISOR_OUT = 7'h08;
			CONV_DIV32: CONVERTER_DIVISOR_OUT = 7'h20;
			CONV_DIV4: CONVERTER_DIVISOR_OUT = 7'h04;
			CONV_DIV16: CONVERTER_DIVISOR_OUT = 7'h10;
			CONV_DIV64: CONVERTER_DIVISOR_OUT = 7'h40;
			default: begin
				CONVERTER_USE_RC_OUT = 1'b1;
				CONVERTER_DIVISOR_OUT = 7'h00;
			end
		endcase
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// analog select resets to 8'h0F, ones in the four channel bits only
	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			analog_select_reg <= `ANALOG_SELECT_LARGE_RESET;
		end else if (req.wr && (req.addr == `ADDR_ANALOG_SELECT)) begin
			analog_select_reg <= req.wdata & analog_select_large_mask;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			pullup_enable_reg <= `PULLUP_RESET;
		end else if (req.wr && (req.addr == `ADDR_PULLUP_ENABLE)) begin
			// no enable bit for input-only pin
			pullup_enable_reg <= req.wdata & `PULLUP_MASK;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			change_irq_enable_reg <= `CHANGE_RESET;
		end else if (req.wr && (req.addr == `ADDR_CHANGE_ENABLE)) begin
			change_irq_enable_reg <= req.wdata & `CHANGE_MASK;
		end
	end

	// ----------------------------------------
	// Port data, direction and config
	// ----------------------------------------
	// write updates output latch
	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			port_latch_reg <= 6'h00;
		end else if (req.wr && (req.addr == `ADDR_PORT_DATA)) begin
			port_latch_reg <= req.wdata[5:0];
		end
	end

	// Input-only pin never gets a driver
	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			direction_reg <= 6'(`DIRECTION_RESET);
		end else if (req.wr && (req.addr == `ADDR_DIRECTION)) begin
			direction_reg <= req.wdata[5:0] | 6'h08;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			global_irq_enable_reg <= 1'b0;
			port_irq_enable_reg <= 1'b0;
		end else if (req.wr && (req.addr == `ADDR_IRQ_CONTROL)) begin
			global_irq_enable_reg <= req.wdata[`IRQ_GIE_BIT];
			port_irq_enable_reg <= req.wdata[`IRQ_GPIE_BIT];
		end
	end

	// global pull-up control off after reset
	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			global_pullup_control_n_reg <= 1'b1;
			master_clear_reg <= 1'b0;
			osc_pin_mode_reg <= 1'b0;
			large_variant_reg <= 1'b0;
		end else if (req.wr && (req.addr == `ADDR_CONFIG)) begin
			global_pullup_control_n_reg <= req.wdata[`CFG_GLOBAL_PULLUP_CONTROL_N_BIT];
			master_clear_reg <= req.wdata[`CFG_MASTER_CLEAR_BIT];
			osc_pin_mode_reg <= req.wdata[`CFG_OSC_BIT];
			large_variant_reg <= req.wdata[`CFG_LARGE_BIT];
		end
	end

	// ----------------------------------------
	// Change detection
	// ----------------------------------------
	// any port access reloads latch
	assign port_access = (req.rd | req.wr) && (req.addr == `ADDR_PORT_DATA);
	generate
		for (i = 0; i < 6; i++) begin : g_chg
			assign mismatch[i] = (pin_sync[i] ^ last_read_reg[i]) & change_irq_enable_reg[i]
				& ~analog_pins[i];
		end
	endgenerate
	assign mismatch_any = |mismatch;
	assign flag_set = mismatch_any && !port_access;
	// Software clear writes 0 to the flag bit
	assign flag_clear = req.wr && (req.addr == `ADDR_IRQ_CONTROL)
		&& !req.wdata[`IRQ_FLAG_BIT];

	always_ff @(posedge CORE_CLK_IN or negedge POR_N_IN) begin
		if (!POR_N_IN) begin
			last_read_reg <= 6'h00;
		end else if (port_access) begin
			last_read_reg <= pin_sync;
		end
	end

	// ----------------------------------------
	// Change flag
	// ----------------------------------------
	// flag set while mismatch persists
	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			port_change_flag_reg <= 1'b0;
			chg_state_reg <= CHG_IDLE;
		end else begin
			case (chg_state_reg)
				CHG_IDLE: begin
					if (flag_set) begin
						port_change_flag_reg <= 1'b1;
						chg_state_reg <= CHG_FLAGGED;
					end else begin
						chg_state_reg <= CHG_ARMED;
					end
				end
				CHG_ARMED, CHG_FLAGGED: begin
					// Set wins over a clear in the same cycle
					if (flag_set) begin
						port_change_flag_reg <= 1'b1;
						chg_state_reg <= CHG_FLAGGED;
					end else if (flag_clear) begin
						port_change_flag_reg <= 1'b0;
						chg_state_reg <= CHG_ARMED;
					end
				end
				default: chg_state_reg <= CHG_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Interrupt outputs
	// ----------------------------------------
	// wake from sleep
	assign WAKE_OUT = port_change_flag_reg & port_irq_enable_reg;
	assign IRQ_OUT = WAKE_OUT & global_irq_enable_reg;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// crystal modes force bits 5,4
	assign pullup_view = pullup_enable_reg | (osc_pin_mode_reg ? `OSC_PIN_MASK : 8'h00);
	assign change_view = change_irq_enable_reg | (osc_pin_mode_reg ? `OSC_PIN_MASK : 8'h00);
	// analog bits read zero, pin 3 reads zero under master clear, other pins returned
	assign port_view = {2'b00, digital_read & ~({5'h00, master_clear_reg} << 3)};
	// crystal modes force direction bits 5,4
	assign direction_view = {2'b00, direction_reg | (osc_pin_mode_reg ? 6'h30 : 6'h00)};
	assign irq_view = {global_irq_enable_reg, 3'b000, port_irq_enable_reg, 2'b00,
		port_change_flag_reg};
	assign config_view = {4'h0, large_variant_reg, osc_pin_mode_reg, master_clear_reg,
		global_pullup_control_n_reg};

	always_comb begin
		rdata_next = 8'h00;
		if (req.addr == `ADDR_ANALOG_SELECT) begin
			rdata_next = analog_select_reg;
		end else if (req.addr == `ADDR_PULLUP_ENABLE) begin
			rdata_next = pullup_view;
		end else if (req.addr == `ADDR_CHANGE_ENABLE) begin
			rdata_next = change_view;
		end else if (req.addr == `ADDR_PORT_DATA) begin
			rdata_next = port_view;
		end else if (req.addr == `ADDR_DIRECTION) begin
			rdata_next = direction_view;
		end else if (req.addr == `ADDR_IRQ_CONTROL) begin
			rdata_next = irq_view;
		end else if (req.addr == `ADDR_CONFIG) begin
			rdata_next = config_view;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			RDATA_OUT <= 8'h00;
		end else if (req.rd) begin
			RDATA_OUT <= rdata_next;
		end else begin
			RDATA_OUT <= 8'h00;
		end
	end

endmodule // port_extras

// *** logic/port_extras_map.svh ***
// Register offsets, field positions, reset values and timing counts for the port extras block
`ifndef PORT_EXTRAS_MAP_SVH
`define PORT_EXTRAS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_ANALOG_SELECT 4'h0
`define ADDR_PULLUP_ENABLE 4'h1
`define ADDR_CHANGE_ENABLE 4'h2
`define ADDR_PORT_DATA 4'h3
`define ADDR_DIRECTION 4'h4
`define ADDR_IRQ_CONTROL 4'h5
`define ADDR_CONFIG 4'h6

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define ANALOG_SELECT_LARGE_MASK_SMALL 8'h0B
`define ANALOG_SELECT_LARGE_MASK_LARGE 8'h7F
`define PULLUP_MASK 8'h37
`define CHANGE_MASK 8'h3F
`define PORT_MASK 8'h3F
`define OSC_PIN_MASK 8'h30
`define IRQ_FLAG_BIT 0
`define IRQ_GIE_BIT 7
`define IRQ_GPIE_BIT 3
`define CFG_GLOBAL_PULLUP_CONTROL_N_BIT 0
`define CFG_MASTER_CLEAR_BIT 1
`define CFG_OSC_BIT 2
`define CFG_LARGE_BIT 3
`define INPUT_ONLY_PIN 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ANALOG_SELECT_LARGE_RESET 8'h0F
`define PULLUP_RESET 8'h37
`define CHANGE_RESET 8'h00
`define DIRECTION_RESET 8'h3F
`define CONFIG_RESET 8'h01

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define SYNC_STAGES 2

`endif

// *** logic/port_extras_pkg.sv ***
// Types shared by the port extras block
package port_extras_pkg;

	typedef logic [5:0] pin_vec_t;
	typedef logic [7:0] byte_t;

	// Register bus request
	typedef struct packed {
		logic [3:0] addr;
		byte_t wdata;
		logic wr;
		logic rd;
	} bus_req_s;

	// Converter clock source choice
	typedef enum logic [2:0] {
		CONV_DIV2 = 3'b000,
		CONV_DIV8 = 3'b001,
		CONV_DIV32 = 3'b010,
		CONV_RC = 3'b011,
		CONV_DIV4 = 3'b100,
		CONV_DIV16 = 3'b101,
		CONV_DIV64 = 3'b110,
		CONV_RC_ALT = 3'b111
	} conv_clock_e;

	// Change detector state
	typedef enum logic [1:0] {
		CHG_IDLE = 2'b00,
		CHG_ARMED = 2'b01,
		CHG_FLAGGED = 2'b10
	} chg_state_e;

endpackage

// *** logic/pin_sync.sv ***
// Two-stage synchroniser for the port pin inputs
module pin_sync
	import port_extras_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire pin_vec_t async_in,
	output pin_vec_t sync_out
);

	pin_vec_t stage1_reg;
	pin_vec_t stage2_reg;

	// ----------------------------------------
	// Synchroniser flops
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_bit
			always_ff @(posedge clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					stage1_reg[i] <= 1'b0;
					stage2_reg[i] <= 1'b0;
				end else begin
					stage1_reg[i] <= async_in[i];
					stage2_reg[i] <= stage1_reg[i];
				end
			end
		end
	endgenerate

	assign sync_out = stage2_reg;

endmodule // pin_sync

// *** tb/port_extras_assertions.sv ***
// Port-level checker for the port extras block
module port_extras_assertions
	import port_extras_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic RD_IN,
	input wire logic [7:0] RDATA_OUT,
	input wire logic [5:0] PIN_OE_OUT,
	input wire logic [5:0] PULLUP_ON_OUT,
	input wire logic [5:0] DIGITAL_IN_EN_OUT,
	input wire logic [3:0] ANALOG_PIN_SELECT_OUT,
	input wire logic [2:0] CONVERTER_CLOCK_SELECT_OUT,
	input wire logic CONVERTER_USE_RC_OUT,
	input wire logic [6:0] CONVERTER_DIVISOR_OUT,
	input wire logic WAKE_OUT,
	input wire logic IRQ_OUT
);
	logic [2:0] cs;
	logic [3:0] an;
	assign cs = CONVERTER_CLOCK_SELECT_OUT;
	assign an = ANALOG_PIN_SELECT_OUT;
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	sequence s_no_read;
		!RD_IN;
	endsequence
	sequence s_rd_zero;
		RDATA_OUT == 8'h00;
	endsequence
	property p_rd_idle;
		s_no_read |=> s_rd_zero;
	endproperty
	property p_in_buf;
		DIGITAL_IN_EN_OUT == {1'b1, ~an[3], 1'b1, ~an[2:0]};
	endproperty
	property p_pu_out;
		(PULLUP_ON_OUT & PIN_OE_OUT) == 6'h00;
	endproperty
	property p_pu_ana;
		(PULLUP_ON_OUT & ~DIGITAL_IN_EN_OUT) == 6'h00;
	endproperty
	property p_rc;
		CONVERTER_USE_RC_OUT == (cs[1:0] == 2'b11);
	endproperty
	property p_div;
		CONVERTER_DIVISOR_OUT == (cs[1:0] == 2'b11 ? 7'h00 : 7'h01 << (1 + 2 * cs[1:0] + cs[2]));
	endproperty
	property p_irq;
		IRQ_OUT |-> WAKE_OUT;
	endproperty
	property p_oe3;
		PIN_OE_OUT[3] == 1'b0;
	endproperty
	property p_por;
		$rose(RESET_N_IN) |-> (PULLUP_ON_OUT & 6'h37) == 6'h00 && !WAKE_OUT;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_in_buf: assert property (p_in_buf) else $error("input buffer enable wrong");
	a_pu_out: assert property (p_pu_out) else $error("pull-up on output pin");
	a_pu_ana: assert property (p_pu_ana) else $error("pull-up on analog pin");
	a_rc: assert property (p_rc) else $error("rc clock choice wrong");
	a_div: assert property (p_div) else $error("divisor wrong");
	a_irq: assert property (p_irq) else $error("irq without wake");
	a_oe3: assert property (p_oe3) else $error("input-only pin driven");
	a_por: assert property (p_por) else $error("reset state wrong");
endmodule // port_extras_assertions

bind port_extras port_extras_assertions u_chk (.CORE_CLK_IN(CORE_CLK_IN),
	.RESET_N_IN(RESET_N_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .PIN_OE_OUT(PIN_OE_OUT),
	.PULLUP_ON_OUT(PULLUP_ON_OUT), .DIGITAL_IN_EN_OUT(DIGITAL_IN_EN_OUT),
	.ANALOG_PIN_SELECT_OUT(ANALOG_PIN_SELECT_OUT),
	.CONVERTER_CLOCK_SELECT_OUT(CONVERTER_CLOCK_SELECT_OUT),
	.CONVERTER_USE_RC_OUT(CONVERTER_USE_RC_OUT), .CONVERTER_DIVISOR_OUT(CONVERTER_DIVISOR_OUT),
	.WAKE_OUT(WAKE_OUT), .IRQ_OUT(IRQ_OUT));

// *** tb/port_extras_tb.sv ***
// Self-checking bench for the port extras block
module port_extras_tb
	import port_extras_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(x, y) begin num_checks++; if ((x) !== (y)) begin mismatches++; \
$display("BAD %0t got %h want %h", $time, x, y); end end
	logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, wr = 1'b0, rd = 1'b0, use_rc, wake, irq;
	logic [3:0] addr = 4'h0, ana;
	logic [2:0] ccs;
	logic [6:0] div;
	logic [1:0] c;
	byte_t wdata = 8'h00, r = 8'h5E, d, a, l, rdata;
	pin_vec_t pin = 6'h00, dir, pe, pout, oe, pu, din;
	int mismatches = 0, num_checks = 0, cyc = 0;
	logic [3:0] ra [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
	byte_t rv [7] = '{8'h0F, 8'h37, 8'h00, 8'h3F, 8'h00, 8'h01, 8'h00};
	byte_t wv [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h00};
	byte_t we [4] = '{8'h0B, 8'h37, 8'h3F, 8'h08};

	port_extras dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .POR_N_IN(por_n), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PIN_IN(pin),
		.PIN_OUT(pout), .PIN_OE_OUT(oe), .PULLUP_ON_OUT(pu), .DIGITAL_IN_EN_OUT(din),
		.ANALOG_PIN_SELECT_OUT(ana), .CONVERTER_CLOCK_SELECT_OUT(ccs),
		.CONVERTER_USE_RC_OUT(use_rc), .CONVERTER_DIVISOR_OUT(div), .WAKE_OUT(wake),
		.IRQ_OUT(irq));

	initial forever #25 clk = ~clk;

	function automatic byte_t nxt(byte_t s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Analog select bits onto pins 0,1,2,4
	function automatic pin_vec_t amap(byte_t v);
		return {1'b0, v[3], 1'b0, v[2:0]};
	endfunction
	task automatic wrr(input logic [3:0] ad, input byte_t v);
		@(posedge clk);
		addr <= ad;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdd(input logic [3:0] ad, output byte_t v);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rst(input logic full);
		@(posedge clk);
		rst_n <= 1'b0;
		por_n <= !full;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	initial begin
		rst(1'b1);
		for (int i = 0; i < 7; i++) begin
			rdd(ra[i], d);
			`CHK(d, rv[i])
		end
		for (int i = 0; i < 4; i++) begin
			wrr(ra[i], wv[i]);
			rdd(ra[i], d);
			`CHK(d, we[i])
		end
		$display("test 1 done");
		wrr(4'h6, 8'h09);
		wrr(4'h0, 8'hFF);
		rdd(4'h0, d);
		`CHK(d, 8'h7F)
		for (int k = 0; k < 8; k++) begin
			wrr(4'h0, {1'b0, k[2:0], 4'h0});
			hold(1);
			`CHK(ccs, k[2:0])
			`CHK(use_rc, k[1:0] == 2'b11)
			`CHK(div, k[1:0] == 2'b11 ? 7'h00 : 7'h01 << (1 + 2 * k[1:0] + k[2]))
		end
		$display("test 2 done");
		wrr(4'h1, 8'h00);
		wrr(4'h2, 8'h00);
		wrr(4'h6, 8'h05);
		rdd(4'h1, d);
		`CHK(d, 8'h30)
		rdd(4'h2, d);
		`CHK(d, 8'h30)
		$display("test 3 done");
		for (int i = 0; i < 24; i++) begin
			r = nxt(r);
			a = r & 8'h0B;
			wrr(4'h0, r);
			r = nxt(r);
			pe = r[5:0] & 6'h37;
			wrr(4'h1, r);
			r = nxt(r);
			dir = r[5:0] | 6'h08;
			wrr(4'h4, r);
			r = nxt(r);
			l = r;
			wrr(4'h3, r);
			r = nxt(r);
			c = r[1:0];
			wrr(4'h6, {6'h00, c});
			r = nxt(r);
			pin <= r[5:0];
			hold(3);
			`CHK(pu & 6'h37, pe & dir & ~amap(a) & {6{~c[0]}})
			if (!c[0])
				`CHK(pu[3], c[1])
			`CHK(oe, ~dir)
			`CHK(pout & 6'h37, l[5:0] & 6'h37)
			`CHK(din, ~amap(a))
			`CHK(ana, a[3:0])
			rdd(4'h3, d);
			`CHK(d, {2'b00, pin & ~amap(a) & ~(6'h08 & {6{c[1]}})})
		end
		$display("test 4 done");
		wrr(4'h6, 8'h00);
		wrr(4'h0, 8'h00);
		wrr(4'h2, 8'h3F);
		pin <= 6'h15;
		hold(3);
		rdd(4'h3, d);
		wrr(4'h5, 8'h88);
		hold(2);
		`CHK(wake, 1'b0)
		@(posedge clk) pin <= 6'h14;
		hold(4);
		`CHK(wake, 1'b1)
		`CHK(irq, 1'b1)
		rdd(4'h5, d);
		`CHK(d, 8'h89)
		wrr(4'h5, 8'h88);
		hold(2);
		`CHK(wake, 1'b1)
		wrr(4'h5, 8'h08);
		hold(1);
		`CHK(irq, 1'b0)
		rdd(4'h3, d);
		wrr(4'h5, 8'h88);
		hold(2);
		`CHK(wake, 1'b0)
		wrr(4'h4, 8'h3F);
		wrr(4'h0, 8'h01);
		pin <= 6'h15;
		hold(4);
		`CHK(wake, 1'b0)
		wrr(4'h0, 8'h00);
		hold(3);
		`CHK(wake, 1'b1)
		$display("test 5 done");
		for (int j = 0; j < 2; j++) begin
			if (j == 1)
				@(posedge clk) pin <= 6'h00;
			rst(j[0]);
			wrr(4'h0, 8'h00);
			wrr(4'h2, 8'h3F);
			wrr(4'h5, 8'h08);
			hold(3);
			`CHK(wake, !j[0])
		end
		$display("test 6 done");
		print_verdict();
	end
endmodule // port_extras_tb
